// File: pin_mux_map.svh
// Constants for the port H/J/L/S pin function multiplexer
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH
`define H_WIDTH 3
`define J_WIDTH 6
`define L_WIDTH 7
`define S_WIDTH 2
// Port J vector positions: 5=line 7, 4=line 6, 3..0=lines 3..0
`define J_SCL 5
`define J_SDA 4
`define J_COL 3
`define J_CRS 2
`define J_MDIO 1
`define J_MDC 0
// Port S vector positions: 1=line 7, 0=line 6
`define S_SS 1
`define S_SCK 0
// Port L indicator field is lines 4..0
`define L_LED_WIDTH 5
`define RESET_ZERO 1'b0
`endif

// File: pin_mux_pkg.sv
// Types for the port H/J/L/S pin function multiplexer
package pin_mux_pkg;
    typedef logic [2:0] h_vec_t;
    typedef logic [5:0] j_vec_t;
    typedef logic [6:0] l_vec_t;
    typedef logic [1:0] s_vec_t;
endpackage

// File: pin_cell.sv
// One pad cell: peripheral-over-GPIO selection, registered outputs
module pin_cell (
    input wire logic clock,
    input wire logic resetn,
    input wire logic alt_en,
    input wire logic alt_out,
    input wire logic alt_drive,
    input wire logic gpio_out,
    input wire logic gpio_dir,
    output logic pad_out,
    output logic pad_oe_n
);
    logic out_q, out_d, oe_n_q, oe_n_d;

    // Enabled peripheral wins; otherwise GPIO register steers the pad
    always_comb begin
        out_d = alt_en ? alt_out : gpio_out;
        oe_n_d = alt_en ? ~alt_drive : ~gpio_dir;
    end

    // Reset leaves the pad as high-impedance input
    always_ff @(posedge clock) begin
        if (!resetn) begin
            out_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            out_q <= out_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign pad_out = out_q;
    assign pad_oe_n = oe_n_q;
endmodule

// File: port_hjls_pin_function_mux.sv
// Pin function multiplexer for port H 2..0, J 7,6,3..0, L 6..0, S 7..6
//
// Contract
// - With the MII enabled, MAC transmit data bits 2..0 drive port H 2..0.
// - With the MII enabled, port J line 3 feeds the MAC collision input.
// - With the MII enabled, port J line 2 feeds the MAC carrier sense.
// - With the MII enabled, port J line 1 is the two-way management data.
// - With the MII enabled, port J line 0 drives the management clock.
// - With I2C enabled, port J line 7 is the I2C clock line.
// - With I2C enabled, port J line 6 is the I2C data line.
// - With PHY and LED enable set, port L 4..0 show the five indicators.
// - With SPI enabled, port S line 7 is the slave select.
// - With SPI enabled, port S line 6 is the SPI clock.
// - Port H 2..0 and J 7,6,3..0 each can raise a key-wakeup interrupt.
// - In and just after reset every pin is a high-impedance input.
// - Port L lines 6 and 5 are GPIO only.
`include "pin_mux_map.svh"
module port_hjls_pin_function_mux (
    input wire logic clock,
    input wire logic resetn,
    // Peripheral enables
    input wire logic mii_enable,
    input wire logic i2c_enable,
    input wire logic spi_enable,
    input wire logic phy_enable,
    input wire logic status_led_enable,
    // MAC side
    input wire pin_mux_pkg::h_vec_t mac_txd,
    input wire logic mac_mdio_out,
    input wire logic mac_mdio_drive,
    input wire logic mac_mdc,
    output logic mac_col,
    output logic mac_crs,
    output logic mac_mdio_in,
    // I2C side: open drain, module pulls low when drive is set
    input wire logic i2c_scl_drive,
    input wire logic i2c_sda_drive,
    output logic i2c_scl_in,
    output logic i2c_sda_in,
    // SPI side
    input wire logic spi_ss_out,
    input wire logic spi_sck_out,
    input wire logic spi_master,
    output logic spi_ss_in,
    output logic spi_sck_in,
    // PHY indicators, order: collision, duplex, speed, link, activity
    input wire logic collision_indicator,
    input wire logic duplex_indicator,
    input wire logic speed_indicator,
    input wire logic link_indicator,
    input wire logic activity_indicator,
    // GPIO port registers
    input wire pin_mux_pkg::h_vec_t h_gpio_out,
    input wire pin_mux_pkg::h_vec_t h_gpio_dir,
    input wire pin_mux_pkg::j_vec_t j_gpio_out,
    input wire pin_mux_pkg::j_vec_t j_gpio_dir,
    input wire pin_mux_pkg::l_vec_t l_gpio_out,
    input wire pin_mux_pkg::l_vec_t l_gpio_dir,
    input wire pin_mux_pkg::s_vec_t s_gpio_out,
    input wire pin_mux_pkg::s_vec_t s_gpio_dir,
    output pin_mux_pkg::h_vec_t h_gpio_in,
    output pin_mux_pkg::j_vec_t j_gpio_in,
    output pin_mux_pkg::l_vec_t l_gpio_in,
    output pin_mux_pkg::s_vec_t s_gpio_in,
    // Key wakeup configuration
    input wire pin_mux_pkg::h_vec_t h_wakeup_en,
    input wire pin_mux_pkg::h_vec_t h_wakeup_rise,
    input wire pin_mux_pkg::h_vec_t h_wakeup_clr,
    input wire pin_mux_pkg::j_vec_t j_wakeup_en,
    input wire pin_mux_pkg::j_vec_t j_wakeup_rise,
    input wire pin_mux_pkg::j_vec_t j_wakeup_clr,
    output pin_mux_pkg::h_vec_t h_wakeup_flag,
    output pin_mux_pkg::j_vec_t j_wakeup_flag,
    output logic wakeup_irq,
    // Pads: input, output, active-low output enable
    input wire pin_mux_pkg::h_vec_t porth_pad_in,
    output pin_mux_pkg::h_vec_t porth_pad_out,
    output pin_mux_pkg::h_vec_t porth_pad_oe_n,
    input wire pin_mux_pkg::j_vec_t portj_pad_in,
    output pin_mux_pkg::j_vec_t portj_pad_out,
    output pin_mux_pkg::j_vec_t portj_pad_oe_n,
    input wire pin_mux_pkg::l_vec_t portl_pad_in,
    output pin_mux_pkg::l_vec_t portl_pad_out,
    output pin_mux_pkg::l_vec_t portl_pad_oe_n,
    input wire pin_mux_pkg::s_vec_t ports_pad_in,
    output pin_mux_pkg::s_vec_t ports_pad_out,
    output pin_mux_pkg::s_vec_t ports_pad_oe_n
);
    import pin_mux_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Alternate function selection, per pin
    h_vec_t h_alt_en, h_alt_out, h_alt_drv;
    j_vec_t j_alt_en, j_alt_out, j_alt_drv;
    l_vec_t l_alt_en, l_alt_out, l_alt_drv;
    s_vec_t s_alt_en, s_alt_out, s_alt_drv;
    logic led_active;

    assign led_active = phy_enable & status_led_enable;

    // Port H carries MAC transmit data as plain outputs
    assign h_alt_en = {`H_WIDTH{mii_enable}};
    assign h_alt_out = mac_txd;
    assign h_alt_drv = {`H_WIDTH{1'b1}};

    // Port J: COL/CRS are inputs, MDIO two-way, MDC out; I2C open drain
    always_comb begin
        j_alt_en = {{2{i2c_enable}}, {4{mii_enable}}};
        j_alt_out = '0;
        j_alt_drv = '0;
        j_alt_out[`J_MDIO] = mac_mdio_out;
        j_alt_drv[`J_MDIO] = mac_mdio_drive;
        j_alt_out[`J_MDC] = mac_mdc;
        j_alt_drv[`J_MDC] = 1'b1;
        // Open drain: only ever pull low, release otherwise
        j_alt_drv[`J_SCL] = i2c_scl_drive;
        j_alt_drv[`J_SDA] = i2c_sda_drive;
    end

    // Port L: lines 6,5 never get an alternate function
    assign l_alt_en = {2'b00, {`L_LED_WIDTH{led_active}}};
    assign l_alt_out = {2'b00, collision_indicator, duplex_indicator,
        speed_indicator, link_indicator, activity_indicator};
    assign l_alt_drv = {2'b00, {`L_LED_WIDTH{1'b1}}};

    // Port S: SS and SCK are outputs in master mode, inputs as slave
    assign s_alt_en = {`S_WIDTH{spi_enable}};
    assign s_alt_out = {spi_ss_out, spi_sck_out};
    assign s_alt_drv = {`S_WIDTH{spi_master}};

    ////////////////////////////////////////////////////////////////////////
    // Pad cells, all reset to high-impedance input
    localparam int NPIN = `H_WIDTH + `J_WIDTH + `L_WIDTH + `S_WIDTH;
    logic [NPIN-1:0] a_en, a_out, a_drv, g_out, g_dir, p_out, p_oe_n;
    assign a_en = {s_alt_en, l_alt_en, j_alt_en, h_alt_en};
    assign a_out = {s_alt_out, l_alt_out, j_alt_out, h_alt_out};
    assign a_drv = {s_alt_drv, l_alt_drv, j_alt_drv, h_alt_drv};
    assign g_out = {s_gpio_out, l_gpio_out, j_gpio_out, h_gpio_out};
    assign g_dir = {s_gpio_dir, l_gpio_dir, j_gpio_dir, h_gpio_dir};

    for (genvar i = 0; i < NPIN; i++) begin : g_cell
        pin_cell u_cell (
            .clock(clock),
            .resetn(resetn),
            .alt_en(a_en[i]),
            .alt_out(a_out[i]),
            .alt_drive(a_drv[i]),
            .gpio_out(g_out[i]),
            .gpio_dir(g_dir[i]),
            .pad_out(p_out[i]),
            .pad_oe_n(p_oe_n[i])
        );
    end

    assign porth_pad_out = p_out[2:0];
    assign porth_pad_oe_n = p_oe_n[2:0];
    assign portj_pad_out = p_out[8:3];
    assign portj_pad_oe_n = p_oe_n[8:3];
    assign portl_pad_out = p_out[15:9];
    assign portl_pad_oe_n = p_oe_n[15:9];
    assign ports_pad_out = p_out[17:16];
    assign ports_pad_oe_n = p_oe_n[17:16];

    ////////////////////////////////////////////////////////////////////////
    // Registered input paths to peripherals and GPIO readback
    logic col_q, crs_q, mdio_q, scl_q, sda_q, ss_q, sck_q;
    logic col_d, crs_d, mdio_d, scl_d, sda_d, ss_d, sck_d;
    h_vec_t hin_q;
    j_vec_t jin_q;
    l_vec_t lin_q;
    s_vec_t sin_q;

    // Disabled peripherals see an idle level, not pin noise
    always_comb begin
        col_d = mii_enable & portj_pad_in[`J_COL];
        crs_d = mii_enable & portj_pad_in[`J_CRS];
        mdio_d = mii_enable & portj_pad_in[`J_MDIO];
        scl_d = ~i2c_enable | portj_pad_in[`J_SCL];
        sda_d = ~i2c_enable | portj_pad_in[`J_SDA];
        ss_d = ~spi_enable | ports_pad_in[`S_SS];
        sck_d = spi_enable & ports_pad_in[`S_SCK];
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            col_q <= 1'b0;
            crs_q <= 1'b0;
            mdio_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            ss_q <= 1'b1;
            sck_q <= 1'b0;
            hin_q <= '0;
            jin_q <= '0;
            lin_q <= '0;
            sin_q <= '0;
        end else begin
            col_q <= col_d;
            crs_q <= crs_d;
            mdio_q <= mdio_d;
            scl_q <= scl_d;
            sda_q <= sda_d;
            ss_q <= ss_d;
            sck_q <= sck_d;
            hin_q <= porth_pad_in;
            jin_q <= portj_pad_in;
            lin_q <= portl_pad_in;
            sin_q <= ports_pad_in;
        end
    end

    assign mac_col = col_q;
    assign mac_crs = crs_q;
    assign mac_mdio_in = mdio_q;
    assign i2c_scl_in = scl_q;
    assign i2c_sda_in = sda_q;
    assign spi_ss_in = ss_q;
    assign spi_sck_in = sck_q;
    assign h_gpio_in = hin_q;
    assign j_gpio_in = jin_q;
    assign l_gpio_in = lin_q;
    assign s_gpio_in = sin_q;

    ////////////////////////////////////////////////////////////////////////
    // Key wakeup: edge on the raw pad input, against its last sample, sets a sticky flag
    h_vec_t hk_q, hk_d, hprev_q;
    j_vec_t jk_q, jk_d, jprev_q;
    logic irq_q, irq_d;

    // Set beats clear so an edge in the clear cycle is kept
    always_comb begin
        hk_d = (hk_q & ~h_wakeup_clr) | (h_wakeup_en &
            ((h_wakeup_rise & porth_pad_in & ~hprev_q) |
             (~h_wakeup_rise & ~porth_pad_in & hprev_q)));
        jk_d = (jk_q & ~j_wakeup_clr) | (j_wakeup_en &
            ((j_wakeup_rise & portj_pad_in & ~jprev_q) |
             (~j_wakeup_rise & ~portj_pad_in & jprev_q)));
        irq_d = |hk_d | |jk_d;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            hk_q <= '0;
            jk_q <= '0;
            hprev_q <= porth_pad_in; // No false edge from an idle-high pin
            jprev_q <= portj_pad_in;
            irq_q <= `RESET_ZERO;
        end else begin
            hk_q <= hk_d;
            jk_q <= jk_d;
            hprev_q <= porth_pad_in;
            jprev_q <= portj_pad_in;
            irq_q <= irq_d;
        end
    end

    assign h_wakeup_flag = hk_q;
    assign j_wakeup_flag = jk_q;
    assign wakeup_irq = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    mac_txd_route_a: assert property (@(posedge clock) disable iff (!resetn)
        mii_enable |=> porth_pad_out == $past(mac_txd) && porth_pad_oe_n == 3'h0)
        else $error("tx data not routed");
    col_route_a: assert property (@(posedge clock) disable iff (!resetn)
        mii_enable |=> mac_col == $past(portj_pad_in[3]))
        else $error("collision not routed");
    crs_route_a: assert property (@(posedge clock) disable iff (!resetn)
        mii_enable |=> mac_crs == $past(portj_pad_in[2]))
        else $error("carrier sense not routed");
    mdio_dir_a: assert property (@(posedge clock) disable iff (!resetn)
        mii_enable |=> portj_pad_oe_n[1] == !$past(mac_mdio_drive))
        else $error("mdio direction wrong");
    mdc_drive_a: assert property (@(posedge clock) disable iff (!resetn)
        mii_enable |=> !portj_pad_oe_n[0] && portj_pad_out[0] == $past(mac_mdc))
        else $error("mdc not driven");
    i2c_lines_a: assert property (@(posedge clock) disable iff (!resetn)
        i2c_enable |=> portj_pad_oe_n[5:4] == ~$past({i2c_scl_drive,
        i2c_sda_drive}) && portj_pad_out[5:4] == 2'h0)
        else $error("i2c lines wrong");
    led_route_a: assert property (@(posedge clock) disable iff (!resetn)
        led_active |=> portl_pad_oe_n[4:0] == 5'h00 && portl_pad_out[4] ==
        $past(collision_indicator) && portl_pad_out[0] ==
        $past(activity_indicator))
        else $error("indicator pins wrong");
    spi_route_a: assert property (@(posedge clock) disable iff (!resetn)
        spi_enable && spi_master |=> ports_pad_out == $past({spi_ss_out,
        spi_sck_out}))
        else $error("spi pins wrong");
    wake_set_a: assert property (@(posedge clock) disable iff (!resetn)
        h_wakeup_en[0] && h_wakeup_rise[0] && porth_pad_in[0] &&
        !$past(porth_pad_in[0]) |=> h_wakeup_flag[0] && wakeup_irq)
        else $error("wakeup edge lost");
    reset_hiz_a: assert property (@(posedge clock)
        !resetn |=> &{porth_pad_oe_n, portj_pad_oe_n, portl_pad_oe_n,
        ports_pad_oe_n} && !wakeup_irq)
        else $error("pin driven after reset");
    gpio_only_a: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |=> portl_pad_oe_n[6:5] == ~$past(l_gpio_dir[6:5]))
        else $error("port l 6..5 not gpio");
    gpio_return_a: assert property (@(posedge clock) disable iff (!resetn)
        !mii_enable |=> porth_pad_out == $past(h_gpio_out))
        else $error("gpio not restored");
endmodule

// File: board_pads.sv
// Board-side model of the pads: chip drive or the board's own level
module board_pads (
    input wire pin_mux_pkg::h_vec_t h_out,
    input wire pin_mux_pkg::h_vec_t h_oe_n,
    input wire pin_mux_pkg::h_vec_t h_ext,
    output pin_mux_pkg::h_vec_t h_in,
    input wire pin_mux_pkg::j_vec_t j_out,
    input wire pin_mux_pkg::j_vec_t j_oe_n,
    input wire pin_mux_pkg::j_vec_t j_ext,
    output pin_mux_pkg::j_vec_t j_in,
    input wire pin_mux_pkg::l_vec_t l_out,
    input wire pin_mux_pkg::l_vec_t l_oe_n,
    input wire pin_mux_pkg::l_vec_t l_ext,
    output pin_mux_pkg::l_vec_t l_in,
    input wire pin_mux_pkg::s_vec_t s_out,
    input wire pin_mux_pkg::s_vec_t s_oe_n,
    input wire pin_mux_pkg::s_vec_t s_ext,
    output pin_mux_pkg::s_vec_t s_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import pin_mux_pkg::*;
    // A driving chip wins; a released pin shows the board level, which
    // stands in for pull-ups and other parties so it is never unknown
    assign h_in = (h_out & ~h_oe_n) | (h_ext & h_oe_n);
    assign j_in = (j_out & ~j_oe_n) | (j_ext & j_oe_n);
    assign l_in = (l_out & ~l_oe_n) | (l_ext & l_oe_n);
    assign s_in = (s_out & ~s_oe_n) | (s_ext & s_oe_n);
endmodule

// File: port_hjls_pin_function_mux_test.sv
// Self-checking bench for the port H/J/L/S pin function multiplexer
module port_hjls_pin_function_mux_test import pin_mux_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic mii_enable, i2c_enable, spi_enable, phy_enable, status_led_enable;
    logic mac_mdio_out, mac_mdio_drive, mac_mdc, i2c_scl_drive;
    logic i2c_sda_drive, spi_ss_out, spi_sck_out, spi_master;
    logic collision_indicator, duplex_indicator, speed_indicator;
    logic link_indicator, activity_indicator, mac_col, mac_crs;
    logic mac_mdio_in, i2c_scl_in, i2c_sda_in, spi_ss_in, spi_sck_in;
    logic wakeup_irq;
    h_vec_t mac_txd, h_gpio_out, h_gpio_dir, h_wakeup_en, h_wakeup_rise;
    h_vec_t h_wakeup_clr, h_ext, h_gpio_in, h_wakeup_flag;
    h_vec_t porth_pad_in, porth_pad_out, porth_pad_oe_n;
    j_vec_t j_gpio_out, j_gpio_dir, j_wakeup_en, j_wakeup_rise;
    j_vec_t j_wakeup_clr, j_ext, j_gpio_in, j_wakeup_flag;
    j_vec_t portj_pad_in, portj_pad_out, portj_pad_oe_n;
    l_vec_t l_gpio_out, l_gpio_dir, l_ext, l_gpio_in;
    l_vec_t portl_pad_in, portl_pad_out, portl_pad_oe_n;
    s_vec_t s_gpio_out, s_gpio_dir, s_ext, s_gpio_in;
    s_vec_t ports_pad_in, ports_pad_out, ports_pad_oe_n;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////
    // 8 ns clock; the ceiling of 2000 cycles is far above the 56 or so cycles needed
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            end_of_test();
        end
    end

    port_hjls_pin_function_mux i_dut (.clock, .resetn, .mii_enable,
        .i2c_enable, .spi_enable, .phy_enable, .status_led_enable, .mac_txd,
        .mac_mdio_out, .mac_mdio_drive, .mac_mdc, .mac_col, .mac_crs,
        .mac_mdio_in, .i2c_scl_drive, .i2c_sda_drive, .i2c_scl_in,
        .i2c_sda_in, .spi_ss_out, .spi_sck_out, .spi_master, .spi_ss_in,
        .spi_sck_in, .collision_indicator, .duplex_indicator,
        .speed_indicator, .link_indicator, .activity_indicator, .h_gpio_out,
        .h_gpio_dir, .j_gpio_out, .j_gpio_dir, .l_gpio_out, .l_gpio_dir,
        .s_gpio_out, .s_gpio_dir, .h_gpio_in, .j_gpio_in, .l_gpio_in,
        .s_gpio_in, .h_wakeup_en, .h_wakeup_rise, .h_wakeup_clr,
        .j_wakeup_en, .j_wakeup_rise, .j_wakeup_clr, .h_wakeup_flag,
        .j_wakeup_flag, .wakeup_irq, .porth_pad_in, .porth_pad_out,
        .porth_pad_oe_n, .portj_pad_in, .portj_pad_out, .portj_pad_oe_n,
        .portl_pad_in, .portl_pad_out, .portl_pad_oe_n, .ports_pad_in,
        .ports_pad_out, .ports_pad_oe_n);

    board_pads i_board (.h_out(porth_pad_out), .h_oe_n(porth_pad_oe_n),
        .h_ext(h_ext), .h_in(porth_pad_in), .j_out(portj_pad_out),
        .j_oe_n(portj_pad_oe_n), .j_ext(j_ext), .j_in(portj_pad_in),
        .l_out(portl_pad_out), .l_oe_n(portl_pad_oe_n), .l_ext(l_ext),
        .l_in(portl_pad_in), .s_out(ports_pad_out), .s_oe_n(ports_pad_oe_n),
        .s_ext(s_ext), .s_in(ports_pad_in));

    ////////////////////////////////////////////////////////////////////////
    // Inputs only change at the falling edge, clear of the sampling edge
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic cmp(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    task automatic end_of_test();
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset: every pad released, also across the first edge after it
    task automatic t_reset();
        for (int k = 0; k < 2; k++) begin
            cmp("h_oe_n", 8'h07, porth_pad_oe_n);
            cmp("j_oe_n", 8'h3f, portj_pad_oe_n);
            cmp("l_oe_n", 8'h7f, portl_pad_oe_n);
            cmp("s_oe_n", 8'h03, ports_pad_oe_n);
            cmp("irq", 8'h00, wakeup_irq);
            resetn = 1'b1;
            step(1);
        end
    endtask

    // Plain GPIO on port H: direction, output level and readback
    task automatic t_gpio();
        h_gpio_dir = 3'h5;
        h_gpio_out = 3'h4;
        h_ext = 3'h2;
        step(3);
        cmp("h_oe_n", 8'h02, porth_pad_oe_n);
        cmp("h_gpio_in", 8'h06, h_gpio_in);
    endtask

    // MII takes port H 2..0 and port J 3..0, and hands them back
    task automatic t_mii();
        h_gpio_dir = 3'h7;
        h_gpio_out = 3'h2;
        {mii_enable, mac_txd, mac_mdc, mac_mdio_drive} = 6'h37;
        j_ext = 6'h0c;
        step(3);
        cmp("h_out", 8'h05, porth_pad_out);
        cmp("h_oe_n", 8'h00, porth_pad_oe_n);
        cmp("j_oe_n", 8'h0c, portj_pad_oe_n & 6'h0f);
        cmp("j_out", 8'h01, portj_pad_out & 6'h03);
        cmp("col_crs", 8'h03, {mac_col, mac_crs});
        cmp("mdio_in", 8'h00, mac_mdio_in);
        mac_mdio_drive = 1'b0;
        j_ext = 6'h02;
        step(3);
        cmp("mdio_in", 8'h01, mac_mdio_in);
        cmp("col_crs", 8'h00, {mac_col, mac_crs});
        mii_enable = 1'b0;
        step(3);
        cmp("h_out", 8'h02, porth_pad_out);
        cmp("j_oe_n", 8'h0f, portj_pad_oe_n & 6'h0f);
    endtask

    // I2C lines are open drain even where GPIO would drive high
    task automatic t_i2c();
        {j_gpio_dir, j_gpio_out, j_ext} = {6'h30, 6'h30, 6'h30};
        {i2c_enable, i2c_scl_drive} = 2'b11;
        step(3);
        cmp("j_oe_n", 8'h10, portj_pad_oe_n & 6'h30);
        cmp("j_out", 8'h00, portj_pad_out[5]);
        cmp("scl_sda", 8'h01, {i2c_scl_in, i2c_sda_in});
        cmp("j_gpio_in", 8'h10, j_gpio_in);
        {i2c_scl_drive, i2c_sda_drive} = 2'b01;
        step(3);
        cmp("j_oe_n", 8'h20, portj_pad_oe_n & 6'h30);
        cmp("scl_sda", 8'h02, {i2c_scl_in, i2c_sda_in});
        {i2c_enable, i2c_sda_drive, j_gpio_dir, j_gpio_out, j_ext} = '0;
    endtask

    // Indicators on port L 4..0 need both enables; lines 6 and 5 stay GPIO
    task automatic t_led();
        {collision_indicator, duplex_indicator, speed_indicator} = 3'b101;
        {link_indicator, activity_indicator} = 2'b10;
        {l_gpio_dir, l_gpio_out} = {7'h60, 7'h20};
        {phy_enable, status_led_enable} = 2'b11;
        step(3);
        cmp("l_out", 8'h36, portl_pad_out);
        cmp("l_oe_n", 8'h00, portl_pad_oe_n);
        cmp("l_gpio_in", 8'h36, l_gpio_in);
        status_led_enable = 1'b0;
        step(3);
        cmp("l_oe_n", 8'h1f, portl_pad_oe_n);
    endtask

    // SPI drives SS and SCK as master, listens to them as slave
    task automatic t_spi();
        {spi_enable, spi_master, spi_ss_out, spi_sck_out} = 4'b1101;
        s_gpio_dir = 2'h0;
        step(3);
        cmp("s_oe_n", 8'h00, ports_pad_oe_n);
        cmp("s_out", 8'h01, ports_pad_out);
        spi_master = 1'b0;
        s_ext = 2'h1;
        step(3);
        cmp("s_oe_n", 8'h03, ports_pad_oe_n);
        cmp("ss_sck", 8'h01, {spi_ss_in, spi_sck_in});
        cmp("s_gpio_in", 8'h01, s_gpio_in);
        spi_enable = 1'b0;
        step(3);
        cmp("ss_sck", 8'h02, {spi_ss_in, spi_sck_in});
    endtask

    // Wakeup: rising edges on H lines 2 and 0, falling edge on J line 0, clear
    task automatic t_wake();
        {h_gpio_dir, j_ext, h_ext} = {3'h0, 6'h3f, 3'h0};
        step(3);
        {h_wakeup_en, h_wakeup_rise, j_wakeup_en} = {3'h7, 3'h7, 6'h3f};
        step(2);
        h_ext = 3'h5;
        step(3);
        cmp("h_flag", 8'h05, h_wakeup_flag);
        cmp("irq", 8'h01, wakeup_irq);
        h_wakeup_clr = 3'h7;
        step(2);
        h_wakeup_clr = 3'h0;
        step(2);
        cmp("irq", 8'h00, wakeup_irq);
        j_ext = 6'h3e;
        step(3);
        cmp("j_flag", 8'h01, j_wakeup_flag);
        // Clear and a new edge in one cycle: the new edge must survive
        {j_wakeup_clr, j_ext} = {6'h3f, 6'h3c};
        step(1);
        j_wakeup_clr = 6'h00;
        step(1);
        cmp("j_flag", 8'h02, j_wakeup_flag);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: everything defined at time zero, reset for 4 cycles
    initial begin
        {mii_enable, i2c_enable, spi_enable, phy_enable} = '0;
        {status_led_enable, mac_mdio_out, mac_mdio_drive, mac_mdc} = '0;
        {i2c_scl_drive, i2c_sda_drive, spi_ss_out, spi_sck_out} = '0;
        {spi_master, collision_indicator, duplex_indicator} = '0;
        {speed_indicator, link_indicator, activity_indicator} = '0;
        {mac_txd, h_gpio_out, h_gpio_dir, h_ext} = '0;
        {h_wakeup_en, h_wakeup_rise, h_wakeup_clr} = '0;
        {j_gpio_out, j_gpio_dir, j_ext, j_wakeup_en} = '0;
        {j_wakeup_rise, j_wakeup_clr, l_gpio_out, l_gpio_dir, l_ext} = '0;
        {s_gpio_out, s_gpio_dir, s_ext} = '0;
        step(4);
        t_reset();
        t_gpio();
        t_mii();
        t_i2c();
        t_led();
        t_spi();
        t_wake();
        end_of_test();
    end
endmodule
